//--- hw/rxlm_pkg.sv
// rxlm_pkg: offsets, reset values, field positions and carrier types for
// the receive link monitor register bank.
// assumes an 8-bit register port and one 40 MHz system clock.
package rxlm_pkg;

    // register offsets (byte wide registers)
    localparam logic [7:0] OFS_A_REM_IRQ_EN   = 8'h3D;
    localparam logic [7:0] OFS_A_LB_CELL_CNT  = 8'h3E;
    localparam logic [7:0] OFS_A_CTRL         = 8'h3F;
    localparam logic [7:0] OFS_A_CELL_THR     = 8'h40;
    localparam logic [7:0] OFS_A_FRAME_THR    = 8'h41;
    localparam logic [7:0] OFS_A_DESCR_THR    = 8'h42;
    localparam logic [7:0] OFS_A_BEC_HIGH     = 8'h43;
    localparam logic [7:0] OFS_A_BEC_MID      = 8'h44;
    localparam logic [7:0] OFS_A_BEC_LOW      = 8'h45;
    localparam logic [7:0] OFS_A_LOCK_STATUS  = 8'h46;
    localparam logic [7:0] OFS_B_RX_LABEL     = 8'h60;
    localparam logic [7:0] OFS_B_EXP_LABEL    = 8'h61;
    localparam logic [7:0] OFS_B_LOCAL_ALARMS = 8'h62;
    localparam logic [7:0] OFS_B_IRQ_EN       = 8'h63;
    localparam logic [7:0] OFS_B_MSG_FIRST    = 8'h66;
    localparam logic [7:0] OFS_B_MSG_LAST     = 8'h6D;

    // reset values
    localparam logic [7:0] RST_CELL_THR  = 8'h78;
    localparam logic [7:0] RST_FRAME_THR = 8'h78;
    localparam logic [7:0] RST_DESCR_THR = 8'h88;

    // control register fields
    localparam int CTRL_LOOPBACK_BIT = 0;
    localparam int CTRL_BEC_MODE_BIT = 1;

    // port B local alarm field positions
    localparam int ALM_LABEL_CHANGED  = 6;
    localparam int ALM_LABEL_MISMATCH = 5;
    localparam int ALM_STATUS_CHANGED = 4;
    localparam int ALM_UNLOCK_LSB     = 1;
    localparam int ALM_BUF_FULL       = 0;

    // counter width, message buffer size and saturation value
    localparam int         BEC_W     = 24;
    localparam int         MSG_BYTES = 8;
    localparam logic [3:0] CONF_MAX  = 4'hF;

    // delineation lock state, one-hot
    typedef enum logic [1:0] {
        RXLM_UNLOCKED = 2'b01,
        RXLM_LOCKED   = 2'b10
    } rxlm_lock_e;

    // one header check outcome from the receive datapath
    typedef struct packed {
        logic valid;
        logic ok;
    } rxlm_hdr_check_s;

    // lock machine state with its consecutive or confidence count
    typedef struct packed {
        rxlm_lock_e st;
        logic [3:0] cnt;
    } rxlm_delin_s;

endpackage

//--- hw/rxlm_regs.sv
// rxlm_regs: receive link monitor register bank with lock machines,
// saturating counters, label check and message buffer handshake.
// assumes inputs synchronous to clk_sys_i and a master that never
// issues read and write strobes in the same cycle.
`timescale 1ns/1ps
`default_nettype none

module rxlm_regs
(
    // clock and reset
    input  wire logic                          clk_sys_i,
    input  wire logic                          rstn_i,
    // register port
    input  wire logic [7:0]                    reg_addr_i,
    input  wire logic [7:0]                    reg_wdata_i,
    input  wire logic                          reg_wr_i,
    input  wire logic                          reg_rd_i,
    output logic      [7:0]                    reg_rdata_o,
    // port A receive events
    input  wire logic [4:0]                    a_rem_alarm_i,
    input  wire logic                          a_lb_cell_i,
    input  wire logic                          a_bit_err_i,
    input  wire rxlm_pkg::rxlm_hdr_check_s     a_cell_chk_i,
    input  wire rxlm_pkg::rxlm_hdr_check_s     a_frame_chk_i,
    input  wire rxlm_pkg::rxlm_hdr_check_s     a_descr_chk_i,
    // port A status and interrupt
    output logic                               a_container_unlock_o,
    output logic                               a_frame_unlock_o,
    output logic                               a_descr_unlock_o,
    output logic                               up_to_down_loopback_en_o,
    output logic                               a_rem_irq_o,
    // port B receive events
    input  wire logic                          b_label_valid_i,
    input  wire logic [7:0]                    b_label_i,
    input  wire logic [2:0]                    b_unlock_i,
    input  wire logic                          b_msg_valid_i,
    input  wire logic [rxlm_pkg::MSG_BYTES*8-1:0] b_msg_i,
    // port B far-end signalling and interrupt
    output logic                               b_msg_accepted_o,
    output logic                               b_irq_o
);

    // whole register bank state
    typedef struct packed {
        logic [7:0]                     rdata;
        logic [4:0]                     a_rem_ie;
        logic [7:0]                     lb_cnt;
        logic [1:0]                     ctrl;
        logic [1:0][7:0]                delin_thr;
        logic [7:0]                     descr_thr;
        rxlm_pkg::rxlm_delin_s [1:0]    delin;
        rxlm_pkg::rxlm_delin_s          descr;
        logic [rxlm_pkg::BEC_W-1:0]     bec;
        logic [rxlm_pkg::BEC_W-1:0]     bec_hold;
        logic [7:0]                     label;
        logic [7:0]                     exp_label;
        logic [6:0]                     alarm;
        logic [6:0]                     b_ie;
        logic [2:0]                     b_unlock_prev;
        logic [rxlm_pkg::MSG_BYTES-1:0][7:0] msg;
        logic                           msg_ack;
        logic                           a_irq;
        logic                           b_irq;
    } rxlm_state_s;

    localparam rxlm_pkg::rxlm_delin_s DELIN_RST =
        '{st: rxlm_pkg::RXLM_UNLOCKED, cnt: 4'h0};
    localparam rxlm_state_s STATE_RST = '{
        delin_thr: {rxlm_pkg::RST_FRAME_THR, rxlm_pkg::RST_CELL_THR},
        descr_thr: rxlm_pkg::RST_DESCR_THR,
        delin:     {DELIN_RST, DELIN_RST},
        descr:     DELIN_RST,
        default:   '0
    };

    rxlm_state_s s_q;
    rxlm_state_s s_d;

    // one step of a consecutive-count delineation machine
    function automatic rxlm_pkg::rxlm_delin_s delin_step(
        input rxlm_pkg::rxlm_delin_s     cur,
        input rxlm_pkg::rxlm_hdr_check_s chk,
        input logic [3:0]                lose_thr,
        input logic [3:0]                gain_thr
    );
        rxlm_pkg::rxlm_delin_s nxt;
        logic [3:0]            inc;
        nxt = cur;
        inc = cur.cnt + 4'h1; // no wrap: count resets before passing the threshold
        if (chk.valid)
        begin
            case (cur.st)
                rxlm_pkg::RXLM_LOCKED:
                begin
                    if (chk.ok)
                        nxt.cnt = 4'h0;
                    else if (inc >= lose_thr)
                        nxt = DELIN_RST;
                    else
                        nxt.cnt = inc;
                end
                rxlm_pkg::RXLM_UNLOCKED:
                begin
                    if (!chk.ok)
                        nxt.cnt = 4'h0;
                    else if (inc >= gain_thr)
                        nxt = '{st: rxlm_pkg::RXLM_LOCKED, cnt: 4'h0};
                    else
                        nxt.cnt = inc;
                end
                default: nxt = DELIN_RST;
            endcase
        end
        return nxt;
    endfunction

    // address decode of the strobes
    logic rd_lb;
    logic rd_bec_hi;
    logic rd_alarm;
    logic wr_alarm;
    logic msg_take;
    logic [3:0] dsc_cnt;
    logic [7:0] msg_idx;
    assign rd_lb     = reg_rd_i && (reg_addr_i == rxlm_pkg::OFS_A_LB_CELL_CNT);
    assign rd_bec_hi = reg_rd_i && (reg_addr_i == rxlm_pkg::OFS_A_BEC_HIGH);
    assign rd_alarm  = reg_rd_i && (reg_addr_i == rxlm_pkg::OFS_B_LOCAL_ALARMS);
    assign wr_alarm  = reg_wr_i && (reg_addr_i == rxlm_pkg::OFS_B_LOCAL_ALARMS);
    assign msg_take  = b_msg_valid_i && !s_q.alarm[rxlm_pkg::ALM_BUF_FULL];
    assign msg_idx   = rxlm_pkg::OFS_B_MSG_LAST - reg_addr_i;

    // next-state logic: register accesses first, then events with set-over-clear merging
    always_comb
    begin
        s_d         = s_q;
        s_d.rdata   = 8'h00;
        s_d.msg_ack = 1'b0;
        dsc_cnt     = s_q.descr.cnt;

        // register reads; unmapped offsets answer zero
        if (reg_rd_i)
        begin
            case (reg_addr_i)
                rxlm_pkg::OFS_A_REM_IRQ_EN:   s_d.rdata = {3'h0, s_q.a_rem_ie};
                rxlm_pkg::OFS_A_LB_CELL_CNT:  s_d.rdata = s_q.lb_cnt;
                rxlm_pkg::OFS_A_CTRL:         s_d.rdata = {6'h00, s_q.ctrl};
                rxlm_pkg::OFS_A_CELL_THR:     s_d.rdata = s_q.delin_thr[0];
                rxlm_pkg::OFS_A_FRAME_THR:    s_d.rdata = s_q.delin_thr[1];
                rxlm_pkg::OFS_A_DESCR_THR:    s_d.rdata = s_q.descr_thr;
                rxlm_pkg::OFS_A_BEC_HIGH:     s_d.rdata = s_q.bec[23:16];
                rxlm_pkg::OFS_A_BEC_MID:      s_d.rdata = s_q.bec_hold[15:8];
                rxlm_pkg::OFS_A_BEC_LOW:      s_d.rdata = s_q.bec_hold[7:0];
                rxlm_pkg::OFS_A_LOCK_STATUS:  s_d.rdata = {5'h00,
                    a_descr_unlock_o, a_frame_unlock_o, a_container_unlock_o};
                rxlm_pkg::OFS_B_RX_LABEL:     s_d.rdata = s_q.label;
                rxlm_pkg::OFS_B_EXP_LABEL:    s_d.rdata = s_q.exp_label;
                rxlm_pkg::OFS_B_LOCAL_ALARMS: s_d.rdata = {1'b0, s_q.alarm};
                rxlm_pkg::OFS_B_IRQ_EN:       s_d.rdata = {1'b0, s_q.b_ie};
                default:
                begin
                    if (reg_addr_i >= rxlm_pkg::OFS_B_MSG_FIRST &&
                        reg_addr_i <= rxlm_pkg::OFS_B_MSG_LAST)
                        s_d.rdata = s_q.msg[msg_idx[2:0]];
                end
            endcase
        end

        // register writes; read-only offsets ignore writes
        if (reg_wr_i)
        begin
            case (reg_addr_i)
                rxlm_pkg::OFS_A_REM_IRQ_EN: s_d.a_rem_ie     = reg_wdata_i[4:0];
                rxlm_pkg::OFS_A_CTRL:       s_d.ctrl         = reg_wdata_i[1:0];
                rxlm_pkg::OFS_A_CELL_THR:   s_d.delin_thr[0] = reg_wdata_i;
                rxlm_pkg::OFS_A_FRAME_THR:  s_d.delin_thr[1] = reg_wdata_i;
                rxlm_pkg::OFS_A_DESCR_THR:  s_d.descr_thr    = reg_wdata_i;
                rxlm_pkg::OFS_B_EXP_LABEL:  s_d.exp_label    = reg_wdata_i;
                rxlm_pkg::OFS_B_IRQ_EN:     s_d.b_ie         = reg_wdata_i[6:0];
                default: ;
            endcase
        end

        // loopback cell count, cleared by read but a new cell still counts
        if (rd_lb)
            s_d.lb_cnt = 8'h00;
        if (s_q.ctrl[rxlm_pkg::CTRL_LOOPBACK_BIT] && a_lb_cell_i &&
            s_d.lb_cnt != 8'hFF)
            s_d.lb_cnt = s_d.lb_cnt + 8'h01;

        // cell and frame delineation machines share one step function
        for (int i = 0; i < 2; i++)
        begin
            s_d.delin[i] = delin_step(s_q.delin[i],
                (i == 0) ? a_cell_chk_i : a_frame_chk_i,
                s_q.delin_thr[i][7:4], s_q.delin_thr[i][3:0]);
        end

        // descrambler confidence counter, direction flips with lock state
        if (a_descr_chk_i.valid)
        begin
            case (s_q.descr.st)
                rxlm_pkg::RXLM_LOCKED:
                begin
                    if (a_descr_chk_i.ok)
                        dsc_cnt = (dsc_cnt == 4'h0) ? 4'h0 : dsc_cnt - 4'h1;
                    else
                        dsc_cnt = (dsc_cnt == rxlm_pkg::CONF_MAX) ?
                                  dsc_cnt : dsc_cnt + 4'h1;
                    if (dsc_cnt >= s_q.descr_thr[7:4])
                        s_d.descr = DELIN_RST;
                    else
                        s_d.descr.cnt = dsc_cnt;
                end
                rxlm_pkg::RXLM_UNLOCKED:
                begin
                    if (a_descr_chk_i.ok)
                        dsc_cnt = (dsc_cnt == rxlm_pkg::CONF_MAX) ?
                                  dsc_cnt : dsc_cnt + 4'h1;
                    else
                        dsc_cnt = (dsc_cnt == 4'h0) ? 4'h0 : dsc_cnt - 4'h1;
                    if (dsc_cnt >= s_q.descr_thr[3:0])
                        s_d.descr = '{st: rxlm_pkg::RXLM_LOCKED, cnt: 4'h0};
                    else
                        s_d.descr.cnt = dsc_cnt;
                end
                default: s_d.descr = DELIN_RST;
            endcase
        end

        // bit error count: high byte read snapshots and clears the live count
        if (rd_bec_hi)
        begin
            s_d.bec_hold = s_q.bec;
            s_d.bec      = '0;
        end
        if (!s_q.ctrl[rxlm_pkg::CTRL_BEC_MODE_BIT])
            s_d.bec = '0;
        else if (a_bit_err_i && s_d.bec != '1)
            s_d.bec = s_d.bec + 24'h00_0001;

        // received label and its change check
        if (b_label_valid_i)
            s_d.label = b_label_i;

        // local alarms: read clears bits 6..1, any pending event wins
        s_d.b_unlock_prev = b_unlock_i;
        if (rd_alarm)
            s_d.alarm[6:1] = 6'h00;
        if (b_label_valid_i && b_label_i != s_q.label)
            s_d.alarm[rxlm_pkg::ALM_LABEL_CHANGED] = 1'b1;
        if (s_q.label != s_q.exp_label)
            s_d.alarm[rxlm_pkg::ALM_LABEL_MISMATCH] = 1'b1;
        if (|(b_unlock_i ^ s_q.b_unlock_prev))
            s_d.alarm[rxlm_pkg::ALM_STATUS_CHANGED] = 1'b1;
        s_d.alarm[3:1] = s_d.alarm[3:1] | b_unlock_i;

        // message buffer: only software empties it, only arrival fills it
        if (wr_alarm && !reg_wdata_i[rxlm_pkg::ALM_BUF_FULL])
            s_d.alarm[rxlm_pkg::ALM_BUF_FULL] = 1'b0;
        if (msg_take)
        begin
            s_d.msg = b_msg_i;
            s_d.alarm[rxlm_pkg::ALM_BUF_FULL] = 1'b1;
            s_d.msg_ack = 1'b1;
        end

        // interrupts are registered, so they trail their cause by one cycle
        s_d.a_irq = |(a_rem_alarm_i & s_q.a_rem_ie);
        s_d.b_irq = |(s_q.alarm & s_q.b_ie);
    end

    // state register
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
            s_q <= STATE_RST;
        else
            s_q <= s_d;
    end

    // outputs straight from state bits
    assign reg_rdata_o = s_q.rdata;
    // one-hot unlocked code is 2'b01, so bit 0 is the unlock flag itself
    assign a_container_unlock_o =
        s_q.delin[0].st[0];
    assign a_frame_unlock_o =
        s_q.delin[1].st[0];
    assign a_descr_unlock_o = s_q.descr.st[0];
    assign up_to_down_loopback_en_o = s_q.ctrl[rxlm_pkg::CTRL_LOOPBACK_BIT];
    assign a_rem_irq_o      = s_q.a_irq;
    assign b_msg_accepted_o = s_q.msg_ack;
    assign b_irq_o          = s_q.b_irq;

    // checks
    chk_irq_gate_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        a_rem_irq_o == $past(|(a_rem_alarm_i & s_q.a_rem_ie)))
        else $error("remote alarm interrupt not gated by enables");
    chk_lb_count_up: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (s_q.ctrl[0] && a_lb_cell_i && !rd_lb && s_q.lb_cnt != 8'hFF)
        |=> s_q.lb_cnt == $past(s_q.lb_cnt) + 8'h01)
        else $error("loopback cell not counted");
    chk_lb_sticks: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (s_q.lb_cnt == 8'hFF && !rd_lb) |=> s_q.lb_cnt == 8'hFF)
        else $error("loopback count left saturation without read");
    chk_cell_unlock: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        $rose(a_container_unlock_o)
        |-> $past(a_cell_chk_i.valid && !a_cell_chk_i.ok))
        else $error("cell lock lost without a bad header");
    chk_cell_gain: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        $fell(a_container_unlock_o)
        |-> $past(a_cell_chk_i.valid && a_cell_chk_i.ok))
        else $error("cell lock gained without a good header");
    chk_frame_unlock: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        $rose(a_frame_unlock_o)
        |-> $past(a_frame_chk_i.valid && !a_frame_chk_i.ok))
        else $error("frame lock lost without a bad check");
    chk_frame_gain: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        $fell(a_frame_unlock_o)
        |-> $past(a_frame_chk_i.valid && a_frame_chk_i.ok))
        else $error("frame lock gained without a good check");
    chk_descr_unlock: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        $rose(a_descr_unlock_o) |-> $past(a_descr_chk_i.valid))
        else $error("descrambler lock changed without a prediction");
    chk_bec_zero: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        !s_q.ctrl[1] |=> s_q.bec == '0)
        else $error("bit error count not held at zero");
    chk_bec_sticks: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (s_q.bec == '1 && !rd_bec_hi && s_q.ctrl[1]) |=> s_q.bec == '1)
        else $error("bit error count wrapped");
    chk_bec_snap: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        rd_bec_hi |=> s_q.bec_hold == $past(s_q.bec))
        else $error("bit error snapshot not captured");
    chk_label_change: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (b_label_valid_i && b_label_i != s_q.label) |=> s_q.alarm[6])
        else $error("label change alarm not set");
    chk_msg_hold: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        s_q.alarm[0] |=> $stable(s_q.msg))
        else $error("full message buffer overwritten");
    chk_msg_accept: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (b_msg_valid_i && !s_q.alarm[0])
        |=> s_q.alarm[0] && b_msg_accepted_o ##1 !b_msg_accepted_o)
        else $error("message arrival not flagged and signalled");

endmodule

`default_nettype wire

//--- dv/rxlm_peer.sv
// rxlm_peer: far-end bridge model sending port B label and messages.
// assumes the bench calls its tasks from the system clock domain.
`timescale 1ns/1ps
`default_nettype none
module rxlm_peer
(
    // clock and acceptance signalling from the bank
    input  wire logic                              clk_i,
    input  wire logic                              accepted_i,
    // port B receive stream
    output logic                                   label_valid_o,
    output logic [7:0]                             label_o,
    output logic                                   msg_valid_o,
    output logic [rxlm_pkg::MSG_BYTES*8-1:0]       msg_o
);
    int n_acc = 0;

    // idle lines start quiet
    initial
    begin
        label_valid_o = 1'b0;
        label_o       = 8'h00;
        msg_valid_o   = 1'b0;
        msg_o         = '0;
    end

    // far end learns buffer state only from these pulses
    always @(posedge clk_i)
        if (accepted_i === 1'b1) n_acc++;

    // stale data inverted so it never passes as a fresh value
    task send_label(input logic [7:0] v);
        @(posedge clk_i);
        label_valid_o <= 1'b1;
        label_o       <= v;
        @(posedge clk_i);
        label_valid_o <= 1'b0;
        label_o       <= ~v;
    endtask

    // one whole message per strobe; no pacing on the acceptance pulse
    task send_msg(input logic [rxlm_pkg::MSG_BYTES*8-1:0] v);
        @(posedge clk_i);
        msg_valid_o <= 1'b1;
        msg_o       <= v;
        @(posedge clk_i);
        msg_valid_o <= 1'b0;
        msg_o       <= ~v;
    endtask
endmodule
`default_nettype wire

//--- dv/tb_top.sv
// tb_top: directed register tests of the receive link monitor bank.
// assumes a 40 MHz clock and the peer model on the port B stream.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic                        clk_sys_i = 1'b0;
    logic                        rstn_i    = 1'b0;
    logic [7:0]                  reg_addr_i = 8'h00;
    logic [7:0]                  reg_wdata_i = 8'h00;
    logic                        reg_wr_i = 1'b0;
    logic                        reg_rd_i = 1'b0;
    logic [7:0]                  reg_rdata_o;
    logic [4:0]                  a_rem_alarm_i = 5'h00;
    logic                        a_lb_cell_i = 1'b0;
    logic                        a_bit_err_i = 1'b0;
    rxlm_pkg::rxlm_hdr_check_s   chk = '0;
    logic [2:0]                  b_unlock_i = 3'h0;
    logic                        cu, fu, du, lben, rirq, lv, mv, acc, birq;
    logic [7:0]                  lbl;
    logic [63:0]                 msg;
    int                          n_fail = 0;
    int                          checked = 0;

    always #12.5 clk_sys_i = ~clk_sys_i;

    rxlm_regs u_rxlm_regs (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .a_rem_alarm_i(a_rem_alarm_i), .a_lb_cell_i(a_lb_cell_i),
        .a_bit_err_i(a_bit_err_i), .a_cell_chk_i(chk), .a_frame_chk_i(chk),
        .a_descr_chk_i(chk), .a_container_unlock_o(cu),
        .a_frame_unlock_o(fu), .a_descr_unlock_o(du),
        .up_to_down_loopback_en_o(lben), .a_rem_irq_o(rirq),
        .b_label_valid_i(lv), .b_label_i(lbl), .b_unlock_i(b_unlock_i),
        .b_msg_valid_i(mv), .b_msg_i(msg), .b_msg_accepted_o(acc),
        .b_irq_o(birq));

    rxlm_peer u_rxlm_peer (.clk_i(clk_sys_i), .accepted_i(acc),
        .label_valid_o(lv), .label_o(lbl), .msg_valid_o(mv), .msg_o(msg));

    task cmp8(input string nm, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e)
        begin
            $display("FAIL %s expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask

    // strobes drop at the sampling edge, so back-to-back calls never clash
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        reg_wr_i    <= 1'b1;
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask

    // read data stand only in the cycle after the read edge
    task rdc(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys_i);
        reg_rd_i   <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1 cmp8($sformatf("reg_%h", a), e, reg_rdata_o);
    endtask

    // n consecutive cycles of one port A event
    task burst(input bit err, input int n);
        @(posedge clk_sys_i);
        if (err) a_bit_err_i <= 1'b1;
        else a_lb_cell_i <= 1'b1;
        repeat (n) @(posedge clk_sys_i);
        a_bit_err_i <= 1'b0;
        a_lb_cell_i <= 1'b0;
    endtask

    // n header checks of one outcome on all three machines
    task chk3(input logic ok, input int n);
        repeat (n)
        begin
            @(posedge clk_sys_i);
            chk <= '{1'b1, ok};
            @(posedge clk_sys_i);
            chk <= '{1'b0, 1'b0};
        end
    endtask

    task finish_test;
        if (n_fail == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // bound on the whole run
    initial
    begin
        repeat (6000) @(posedge clk_sys_i);
        n_fail++;
        finish_test();
    end

    // main sequence
    initial
    begin
        repeat (4) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        rdc(8'h40, 8'h78);
        rdc(8'h41, 8'h78);
        rdc(8'h42, 8'h88);
        rdc(8'h62, 8'h00);
        rdc(8'h3D, 8'h00);
        rdc(8'h50, 8'h00);
        wr(8'h3D, 8'h01);
        a_rem_alarm_i <= 5'h02;
        repeat (3) @(posedge clk_sys_i);
        cmp8("rem_irq", 8'h00, {7'h0, rirq});
        a_rem_alarm_i <= 5'h01;
        repeat (3) @(posedge clk_sys_i);
        cmp8("rem_irq", 8'h01, {7'h0, rirq});
        burst(0, 3);
        rdc(8'h3E, 8'h00);
        wr(8'h3F, 8'h01);
        #1 cmp8("loopback_en", 8'h01, {7'h0, lben});
        burst(0, 3);
        rdc(8'h3E, 8'h03);
        burst(0, 260);
        rdc(8'h3E, 8'hFF);
        rdc(8'h3E, 8'h00);
        burst(1, 4);
        rdc(8'h43, 8'h00);
        rdc(8'h45, 8'h00);
        wr(8'h3F, 8'h02);
        burst(1, 5);
        rdc(8'h43, 8'h00);
        rdc(8'h44, 8'h00);
        rdc(8'h45, 8'h05);
        chk3(1, 7);
        rdc(8'h46, 8'h07);
        chk3(1, 1);
        rdc(8'h46, 8'h00);
        cmp8("cell_unlock", 8'h00, {7'h0, cu});
        chk3(0, 7);
        rdc(8'h46, 8'h03);
        cmp8("frame_descr", 8'h02, {6'h00, fu, du});
        chk3(0, 1);
        rdc(8'h46, 8'h07);
        // expected label moves off the stored zero, so mismatch rises too
        wr(8'h61, 8'h5A);
        u_rxlm_peer.send_label(8'h5A);
        rdc(8'h60, 8'h5A);
        rdc(8'h62, 8'h60);
        rdc(8'h62, 8'h00);
        u_rxlm_peer.send_label(8'hA5);
        wr(8'h60, 8'hFF);
        rdc(8'h60, 8'hA5);
        rdc(8'h62, 8'h60);
        rdc(8'h62, 8'h20);
        wr(8'h61, 8'hA5);
        rdc(8'h62, 8'h20);
        rdc(8'h62, 8'h00);
        @(posedge clk_sys_i);
        b_unlock_i <= 3'b001;
        rdc(8'h62, 8'h12);
        wr(8'h63, 8'h01);
        u_rxlm_peer.send_msg(64'h0123_4567_89AB_CDEF);
        rdc(8'h62, 8'h03);
        cmp8("b_irq", 8'h01, {7'h0, birq});
        rdc(8'h66, 8'h01);
        rdc(8'h6D, 8'hEF);
        u_rxlm_peer.send_msg(64'hFFFF_0000_FFFF_0000);
        rdc(8'h66, 8'h01);
        cmp8("accepted", 8'h01, u_rxlm_peer.n_acc[7:0]);
        wr(8'h62, 8'h00);
        u_rxlm_peer.send_msg(64'hFEDC_BA98_7654_3210);
        rdc(8'h66, 8'hFE);
        cmp8("accepted", 8'h02, u_rxlm_peer.n_acc[7:0]);
        finish_test();
    end
endmodule
`default_nettype wire
